// ### rtl/sit_regs.sv
// Unit identification and null trim registers reached over the serial link.
`timescale 1ns/1ps

module sit_regs
    import sit_pkg::*;
#(
    parameter logic [31:0] UNIT_ID = UNIT_ID_DEFAULT // Per-unit value; default arbitrary.
) (
    input wire logic ref_clk_i, // System clock, 100 MHz.
    input wire logic nrst_i, // Synchronous reset, active low.
    input wire logic sck_i, // Serial clock pin, idles low.
    input wire logic cs_n_i, // Chip select pin, active low.
    input wire logic mosi_i, // Serial data in, sampled on sck rise.
    output logic miso_o, // Serial data out, changes on sck fall.
    output logic miso_oe_o, // High while this block drives miso.
    input wire logic [15:0] rate_i, // Compensated rate from the signal chain.
    input wire logic rate_valid_i, // Rate word strobe.
    output logic [15:0] rate_o, // Trimmed rate to the rate registers.
    output logic rate_valid_o, // Trimmed rate strobe.
    output logic [9:0] null_trim_o, // Current null trim value.
    output logic frame_error_o // One-cycle pulse on a rejected frame.
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic sck_prev;
    logic sck_s;
    logic cs_n_s;
    logic mosi_s;
    logic sck_rise;
    logic sck_fall;

    // Two stages per pin add two system clocks of latency, so the serial
    // clock must stay high and low for at least four system clocks each.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else begin
            pin_meta <= {sck_i, cs_n_i, mosi_i};
            pin_sync <= pin_meta;
        end
    end

    assign sck_s = pin_sync[2];
    assign cs_n_s = pin_sync[1];
    assign mosi_s = pin_sync[0];

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev;
    assign sck_fall = ~sck_s & sck_prev;

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    sit_state_t state;
    sit_state_t next_state;
    logic [4:0] bit_cnt;
    logic [31:0] rx_shift;
    logic [31:0] tx_shift;
    logic [31:0] resp_word;
    logic short_frame;
    logic frame_start;

    always_comb begin
        next_state = state;
        short_frame = 1'b0;
        case (state)
            ST_IDLE: begin
                if (!cs_n_s) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cs_n_s) begin
                    // A frame cut short is dropped whole; nothing is decoded from it.
                    next_state = ST_IDLE;
                    short_frame = 1'b1;
                end else if (sck_rise && bit_cnt == LAST_BIT) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (cs_n_s) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Rises after the 32nd are not counted; the frame waits in hold for select to drop.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            bit_cnt <= 5'h00;
        end else if (state != ST_SHIFT) begin
            bit_cnt <= 5'h00;
        end else if (sck_rise) begin
            bit_cnt <= 5'(bit_cnt + 5'h01);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rx_shift <= 32'h0000_0000;
        end else if (state == ST_SHIFT && sck_rise) begin
            rx_shift <= {rx_shift[30:0], mosi_s};
        end
    end

    assign frame_start = state == ST_IDLE && !cs_n_s;

    // The reply to a request goes out in the following frame, so the word is
    // loaded at select time and the first bit is on the pin before the first rise.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            tx_shift <= RESP_RESET;
        end else if (frame_start) begin
            tx_shift <= resp_word;
        end else if (state != ST_IDLE && sck_fall) begin
            tx_shift <= {tx_shift[30:0], 1'b0};
        end
    end

    assign miso_o = tx_shift[31];

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            miso_oe_o <= 1'b0;
        end else begin
            miso_oe_o <= ~cs_n_s;
        end
    end

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    logic [2:0] req_cmd;
    logic [8:0] req_addr;
    logic [15:0] req_wdata;
    logic req_parity_ok;
    logic req_read;
    logic req_write;
    logic req_bad;

    assign req_cmd = rx_shift[CMD_MSB:CMD_LSB];
    assign req_addr = rx_shift[ADDR_MSB:ADDR_LSB];
    assign req_wdata = rx_shift[WDATA_MSB:WDATA_LSB];
    assign req_parity_ok = ^rx_shift;
    assign req_read = state == ST_EXEC && req_parity_ok && req_cmd == CMD_READ;
    assign req_write = state == ST_EXEC && req_parity_ok && req_cmd == CMD_WRITE;
    assign req_bad = state == ST_EXEC && !(req_read || req_write);

    // ------------------------------------------------------------------
    // Null trim register
    // ------------------------------------------------------------------
    logic [9:0] trim;
    logic [9:0] next_trim;

    // A write names one byte location; a word write at 0x12 fills both bytes,
    // one at 0x13 fills only the low byte from the upper half of the data.
    always_comb begin
        next_trim = trim;
        if (req_write) begin
            if (req_addr == ADDR_TRIM_HIGH) begin
                next_trim = {req_wdata[9:8], req_wdata[7:0]};
            end else if (req_addr == ADDR_TRIM_LOW) begin
                next_trim = {trim[9:8], req_wdata[15:8]};
            end
        end
    end

    // The 10-bit signed field spans -512..+511 counts, about 6.4 deg/s either way.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            trim <= TRIM_RESET;
        end else begin
            trim <= next_trim;
        end
    end

    assign null_trim_o = trim;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_byte(input logic [8:0] a, input logic [9:0] t);
        logic [7:0] b;
        case (a)
            ADDR_UNIT_ID_B3: b = UNIT_ID[31:24];
            ADDR_UNIT_ID_B2: b = UNIT_ID[23:16];
            ADDR_UNIT_ID_B1: b = UNIT_ID[15:8];
            ADDR_UNIT_ID_B0: b = UNIT_ID[7:0];
            ADDR_TRIM_HIGH: b = {TRIM_HIGH_UNUSED, t[9:8]};
            ADDR_TRIM_LOW: b = t[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // Lower address in the upper byte, so 0x0E gives bits 31:16 and 0x10 bits 15:0.
    function automatic logic [15:0] read_word(input logic [8:0] a, input logic [9:0] t);
        logic [8:0] a_next;
        a_next = 9'(a + ADDR_STEP);
        return {read_byte(a, t), read_byte(a_next, t)};
    endfunction

    function automatic logic [31:0] make_resp(
        input logic [2:0] kind,
        input logic [8:0] a,
        input logic [15:0] d
    );
        logic [31:0] w;
        w = {kind, a[7:0], d, 4'h0, 1'b0};
        w[0] = ~^w[31:1];
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Reply word
    // ------------------------------------------------------------------
    logic [2:0] resp_kind;
    logic [15:0] resp_data;

    // A write is answered with the location's content after the write, so the
    // host sees at once whether an attempt on a read-only location took effect.
    // A rejected request carries no data, so stale content is never taken as valid.
    always_comb begin
        resp_kind = KIND_ERROR;
        resp_data = 16'h0000;
        if (req_read) begin
            resp_kind = KIND_READ;
            resp_data = read_word(req_addr, next_trim);
        end else if (req_write) begin
            resp_kind = KIND_WRITE;
            resp_data = read_word(req_addr, next_trim);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            resp_word <= RESP_RESET;
        end else if (state == ST_EXEC) begin
            resp_word <= make_resp(resp_kind, req_addr, resp_data);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            frame_error_o <= 1'b0;
        end else begin
            frame_error_o <= req_bad | short_frame;
        end
    end

    // ------------------------------------------------------------------
    // Rate output path
    // ------------------------------------------------------------------
    sit_rate_trim u_rate_trim (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .rate_i(rate_i),
        .rate_valid_i(rate_valid_i),
        .trim_i(trim),
        .rate_o(rate_o),
        .rate_valid_o(rate_valid_o)
    );

endmodule

// ### pkg/sit_pkg.sv
// Constants and types shared by the unit identification and null trim register bank.
package sit_pkg;

    // ------------------------------------------------------------------
    // Register map (byte locations)
    // ------------------------------------------------------------------
    localparam logic [8:0] ADDR_UNIT_ID_B3 = 9'h00E;
    localparam logic [8:0] ADDR_UNIT_ID_B2 = 9'h00F;
    localparam logic [8:0] ADDR_UNIT_ID_B1 = 9'h010;
    localparam logic [8:0] ADDR_UNIT_ID_B0 = 9'h011;
    localparam logic [8:0] ADDR_TRIM_HIGH = 9'h012;
    localparam logic [8:0] ADDR_TRIM_LOW = 9'h013;
    localparam logic [8:0] ADDR_STEP = 9'h001;

    // Arbitrary default for the per-unit identification value.
    localparam logic [31:0] UNIT_ID_DEFAULT = 32'hC3A5_5A3C;

    // ------------------------------------------------------------------
    // Null trim field
    // ------------------------------------------------------------------
    localparam int TRIM_W = 10;
    localparam logic [9:0] TRIM_RESET = 10'h000;
    localparam logic [5:0] TRIM_HIGH_UNUSED = 6'h00;

    // ------------------------------------------------------------------
    // Rate path
    // ------------------------------------------------------------------
    localparam int RATE_W = 16;
    localparam logic [15:0] RATE_MAX = 16'h7FFF;
    localparam logic [15:0] RATE_MIN = 16'h8000;
    localparam logic [15:0] RATE_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam logic [4:0] LAST_BIT = 5'h1F;
    localparam int CMD_MSB = 31;
    localparam int CMD_LSB = 29;
    localparam int ADDR_MSB = 25;
    localparam int ADDR_LSB = 17;
    localparam int WDATA_MSB = 16;
    localparam int WDATA_LSB = 1;
    localparam logic [2:0] CMD_READ = 3'h4;
    localparam logic [2:0] CMD_WRITE = 3'h2;
    localparam logic [2:0] KIND_READ = 3'h4;
    localparam logic [2:0] KIND_WRITE = 3'h2;
    localparam logic [2:0] KIND_ERROR = 3'h0;
    localparam logic [31:0] RESP_RESET = 32'h0000_0001;

    // Pin synchroniser idle value: {sck, cs_n, mosi}.
    localparam logic [2:0] PIN_IDLE = 3'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SHIFT = 4'h2,
        ST_EXEC = 4'h4,
        ST_HOLD = 4'h8
    } sit_state_t;

endpackage

// ### rtl/sit_rate_trim.sv
// Applies the signed null trim to the compensated rate word.
`timescale 1ns/1ps

module sit_rate_trim
    import sit_pkg::*;
(
    input wire logic ref_clk_i, // System clock.
    input wire logic nrst_i, // Synchronous reset, active low.
    input wire logic [15:0] rate_i, // Compensated rate, two's complement.
    input wire logic rate_valid_i, // Rate word strobe.
    input wire logic [9:0] trim_i, // Null trim, two's complement.
    output logic [15:0] rate_o, // Trimmed rate, registered.
    output logic rate_valid_o // Trimmed rate strobe.
);

    logic [16:0] sum;
    logic [15:0] next_rate;

    // One trim count has the weight of one rate count, so a plain add is exact.
    always_comb begin
        sum = {rate_i[15], rate_i} + {{7{trim_i[9]}}, trim_i};
        if (sum[16] != sum[15]) begin
            // Clip instead of wrapping so a large trim near full scale cannot flip the sign.
            next_rate = sum[16] ? RATE_MIN : RATE_MAX;
        end else begin
            next_rate = sum[15:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rate_o <= RATE_RESET;
        end else if (rate_valid_i) begin
            rate_o <= next_rate;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rate_valid_o <= 1'b0;
        end else begin
            rate_valid_o <= rate_valid_i;
        end
    end

endmodule

// ### tb/sit_regs_chk.sv
// Port-level assertions for the identification and trim register bank.
`timescale 1ns/1ps
module sit_regs_chk
    import sit_pkg::*;
(
    input wire logic ref_clk_i, // Clock.
    input wire logic nrst_i, // Reset, low.
    input wire logic sck_i, // Serial clock.
    input wire logic cs_n_i, // Select, low.
    input wire logic mosi_i, // Request bit.
    input wire logic miso_o, // Reply bit.
    input wire logic miso_oe_o, // Reply enable.
    input wire logic [15:0] rate_i, // Rate in.
    input wire logic rate_valid_i, // Rate strobe in.
    input wire logic [15:0] rate_o, // Rate out.
    input wire logic rate_valid_o, // Rate strobe out.
    input wire logic [9:0] null_trim_o, // Trim.
    input wire logic frame_error_o // Frame error.
);
    logic [16:0] sum;
    logic [15:0] exp_rate;
    // One extra bit exposes overflow so the saturated value can be chosen.
    assign sum = {rate_i[15], rate_i} + {{7{null_trim_o[9]}}, null_trim_o};
    assign exp_rate = (sum[16] != sum[15]) ? (sum[16] ? RATE_MIN : RATE_MAX) : sum[15:0];
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_valid_next: assert property (rate_valid_i |=> rate_valid_o)
        else $error("rate strobe not answered");
    a_valid_cause: assert property (rate_valid_o |-> $past(rate_valid_i))
        else $error("rate strobe without cause");
    a_rate_sum: assert property (rate_valid_i |=> rate_o == $past(exp_rate))
        else $error("trimmed rate wrong");
    a_rate_hold: assert property (!rate_valid_i |=> $stable(rate_o))
        else $error("rate changed without strobe");
    a_trim_in_frame: assert property (!$stable(null_trim_o) |-> miso_oe_o)
        else $error("trim changed outside a frame");
    a_reset_vals: assert property ($rose(nrst_i) |-> null_trim_o == TRIM_RESET
        && rate_o == RATE_RESET && !miso_oe_o)
        else $error("reset values wrong");
    a_oe_idle: assert property (cs_n_i [*4] |=> !miso_oe_o)
        else $error("reply driven while deselected");
    a_oe_active: assert property (!cs_n_i [*5] |=> miso_oe_o)
        else $error("reply not driven in frame");
    a_miso_steady: assert property (sck_i [*4] |-> $stable(miso_o))
        else $error("reply bit moved while clock high");
endmodule

// ### tb/sit_host.sv
// Serial host model that frames requests for the register bank.
`timescale 1ns/1ps
module sit_host (
    input wire logic ref_clk_i, // System clock.
    input wire logic miso_i, // Reply bit.
    output logic sck_o, // Serial clock, low between frames.
    output logic cs_n_o, // Select, active low.
    output logic mosi_o // Request bit.
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // A count below 32 cuts the frame short on purpose.
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = '0;
        cs_n_o <= 1'b0;
        tick(4);
        for (int i = 0; i < nbits; i++) begin
            mosi_o <= tx[31 - i];
            tick(4);
            sck_o <= 1'b1;
            rx[31 - i] = miso_i;
            tick(4);
            sck_o <= 1'b0;
        end
        tick(6);
        cs_n_o <= 1'b1;
        // A released data line must not keep showing its last bit.
        mosi_o <= ~mosi_o;
        tick(8);
    endtask
endmodule

// ### tb/sit_regs_bench.sv
// Self-checking bench for the identification and trim register bank.
`timescale 1ns/1ps
module sit_regs_bench;
    import sit_pkg::*;
    localparam logic [31:0] ID = 32'h6B29_D417; // Arbitrary per-unit value.
    localparam logic [31:0] F = 32'hFFFF_FFFF;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rate_valid_i = 1'b0;
    logic [15:0] rate_i = 16'h0000;
    logic sck, cs_n, mosi, miso, miso_oe, rate_valid_o, frame_error;
    logic [15:0] rate_o;
    logic [9:0] null_trim;
    logic [31:0] rx;
    int mismatches = 0;
    int tests_run = 0;
    int errs = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (frame_error === 1'b1) errs++;
    sit_regs #(.UNIT_ID(ID)) sit_regs_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
        .rate_i(rate_i), .rate_valid_i(rate_valid_i), .rate_o(rate_o),
        .rate_valid_o(rate_valid_o), .null_trim_o(null_trim), .frame_error_o(frame_error));
    sit_host sit_host_inst (.ref_clk_i(ref_clk_i), .miso_i(miso), .sck_o(sck),
        .cs_n_o(cs_n), .mosi_o(mosi));
    function automatic logic [31:0] par(input logic [31:0] w);
        return {w[31:1], ~^w[31:1]};
    endfunction
    function automatic logic [31:0] req(input logic [2:0] c, input logic [8:0] a,
        input logic [15:0] d);
        return par({c, 3'h0, a, d, 1'b0});
    endfunction
    function automatic logic [31:0] rep(input logic [2:0] k, input logic [7:0] a,
        input logic [15:0] d);
        return par({k, a, d, 5'h00});
    endfunction
    task automatic final_report();
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xf(input logic [31:0] tx, input logic [31:0] exp, input logic [31:0] m);
        sit_host_inst.xfer(tx, 32, rx);
        chk(rx & m, exp & m);
    endtask
    task automatic rate(input logic [15:0] r, input logic [15:0] exp);
        @(posedge ref_clk_i);
        rate_i <= r;
        rate_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        rate_valid_i <= 1'b0;
        #1;
        chk({15'h0, rate_valid_o, rate_o}, {16'h0001, exp});
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        mismatches++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        xf(req(CMD_READ, 9'h00E, 16'h0), RESP_RESET, F);
        xf(req(CMD_READ, 9'h010, 16'h0), rep(KIND_READ, 8'h0E, ID[31:16]), F);
        xf(req(CMD_WRITE, 9'h012, 16'h0355), rep(KIND_READ, 8'h10, ID[15:0]), F);
        xf(req(CMD_WRITE, 9'h013, 16'hAB00), rep(KIND_WRITE, 8'h12, 16'h0355), F);
        xf(req(CMD_WRITE, 9'h00F, 16'hFFFF), rep(KIND_WRITE, 8'h13, 16'hAB00), F);
        chk({22'h0, null_trim}, 32'h0000_03AB);
        xf(req(CMD_READ, 9'h0, 16'h0) ^ 32'h1, rep(KIND_WRITE, 8'h0F, ID[23:8]), F);
        chk(32'(errs), 32'h1);
        sit_host_inst.xfer(req(CMD_READ, 9'h012, 16'h0), 8, rx);
        chk(32'(errs), 32'h2);
        xf(req(CMD_READ, 9'h012, 16'h0), rep(KIND_ERROR, 8'h00, 16'h0000), F);
        xf(req(CMD_READ, 9'h00F, 16'h0), rep(KIND_READ, 8'h12, 16'h03AB), F);
        xf(req(CMD_READ, 9'h0, 16'h0), rep(KIND_READ, 8'h0F, ID[23:8]), F);
        rate(16'h1000, 16'h0FAB);
        rate(16'h8010, 16'h8000);
        xf(req(CMD_WRITE, 9'h012, 16'h01FF), rep(KIND_READ, 8'h00, 16'h0000), F);
        rate(16'h7F00, 16'h7FFF);
        rate(16'h0000, 16'h01FF);
        xf(req(CMD_WRITE, 9'h012, 16'h0200), rep(KIND_WRITE, 8'h12, 16'h01FF), F);
        rate(16'h0000, 16'hFE00);
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        xf(req(CMD_READ, 9'h012, 16'h0), RESP_RESET, F);
        chk({22'h0, null_trim}, {22'h0, TRIM_RESET});
        xf(req(CMD_READ, 9'h00E, 16'h0), rep(KIND_READ, 8'h12, {6'h00, TRIM_RESET}), F);
        rate(16'h0100, 16'h0100);
        final_report();
    end
endmodule
bind sit_regs sit_regs_chk sit_regs_chk_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .rate_i(rate_i), .rate_valid_i(rate_valid_i), .rate_o(rate_o),
    .rate_valid_o(rate_valid_o), .null_trim_o(null_trim_o), .frame_error_o(frame_error_o));
